// >>> rtl/dlpwm_chan_if.sv
// Interface joining the register front end to one LED channel.
`timescale 1ns/10ps
`default_nettype none
interface dlpwm_chan_if
    import dlpwm_pkg::*;
();
    logic       tick;
    logic       gate;
    dlpwm_rep_e rep;
    logic       ramp_en;
    logic [5:0] duty_code;
    logic       sink;
    logic [5:0] eff_duty;

    modport ctrl (output tick, output gate, output rep, output ramp_en, output duty_code,
                  input sink, input eff_duty);
    modport chan (input tick, input gate, input rep, input ramp_en, input duty_code,
                  output sink, output eff_duty);
endinterface
`default_nettype wire

// >>> rtl/dlpwm_channel.sv
// One LED sink channel: slot timing, ramping and PWM compare.
`timescale 1ns/10ps
`default_nettype none
module dlpwm_channel
    import dlpwm_pkg::*;
(
    input  wire logic    mclk,
    input  wire logic    reset,
    dlpwm_chan_if.chan   ch
);
    logic [11:0] pre_reg,  pre_next;
    logic [4:0]  slot_reg, slot_next;
    logic [9:0]  ramp_reg, ramp_next;
    logic [5:0]  eff_reg,  eff_next;
    logic [5:0]  app_reg,  app_next;
    logic        sink_reg, sink_next;
    logic        slot_tick;
    logic        ramp_tick;
    logic        period_end;
    logic        ramp_active;
    logic [5:0]  target;

    always_comb begin
        slot_tick  = ch.tick && (pre_reg == dlpwm_prescale(ch.rep) - 12'h001);
        period_end = slot_tick && (slot_reg == SLOT_LAST);
        ramp_tick  = ch.tick && (ramp_reg == RAMP_TICKS - 10'h001);
        target     = dlpwm_duty_of(ch.duty_code);
        ramp_active = ch.ramp_en && (ch.rep == DLPWM_REP_256HZ);

        pre_next  = pre_reg;
        slot_next = slot_reg;
        ramp_next = ramp_reg;
        if (ch.tick) begin
            pre_next  = slot_tick ? 12'h000 : pre_reg + 12'h001;
            ramp_next = ramp_tick ? 10'h000 : ramp_reg + 10'h001;
        end
        // A rate change can leave the prescaler above the new limit; wrap it.
        if (pre_reg >= dlpwm_prescale(ch.rep)) begin
            pre_next = 12'h000;
        end
        if (slot_tick) begin
            slot_next = slot_reg + 5'h01;
        end

        eff_next = eff_reg;
        if (!ramp_active) begin
            eff_next = target;
        end else if (ramp_tick) begin
            if (eff_reg < target) begin
                eff_next = eff_reg + 6'h01;
            end else if (eff_reg > target) begin
                eff_next = eff_reg - 6'h01;
            end
        end

        app_next = period_end ? eff_reg : app_reg;

        sink_next = ch.gate && (app_reg != DUTY_ZERO) && (app_reg > {1'b0, slot_reg});
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pre_reg  <= 12'h000;
            slot_reg <= 5'h00;
            ramp_reg <= 10'h000;
            eff_reg  <= 6'h00;
            app_reg  <= 6'h00;
            sink_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            slot_reg <= slot_next;
            ramp_reg <= ramp_next;
            eff_reg  <= eff_next;
            app_reg  <= app_next;
            sink_reg <= sink_next;
        end
    end

    assign ch.sink     = sink_reg;
    assign ch.eff_duty = eff_reg;
endmodule
`default_nettype wire

// >>> rtl/dlpwm_pkg.sv
// Constants, types and helper functions shared by the dual LED PWM block.
package dlpwm_pkg;

    // Clock and timing base.
    localparam int unsigned MCLK_HZ          = 200_000_000;
    localparam int unsigned TIMING_HZ        = 32_768;
    localparam int unsigned TICK_DIV_DEFAULT = MCLK_HZ / TIMING_HZ;
    localparam int unsigned TICK_CNT_W       = 16;

    // Register bus.
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    localparam logic [3:0] ADDR_CTRL     = 4'h0;
    localparam logic [3:0] ADDR_RED_CFG  = 4'h1;
    localparam logic [3:0] ADDR_RED_DUTY = 4'h2;
    localparam logic [3:0] ADDR_GRN_CFG  = 4'h3;
    localparam logic [3:0] ADDR_GRN_DUTY = 4'h4;
    localparam logic [3:0] ADDR_STATUS   = 4'h5;
    localparam logic [3:0] ADDR_RED_EFF  = 4'h6;
    localparam logic [3:0] ADDR_GRN_EFF  = 4'h7;

    // Field positions.
    localparam int unsigned CTRL_OVR_BIT    = 0;
    localparam int unsigned CTRL_RED_EN_BIT = 1;
    localparam int unsigned CTRL_GRN_EN_BIT = 2;
    localparam int unsigned CFG_LEVEL_LSB   = 0;
    localparam int unsigned CFG_REP_LSB     = 2;
    localparam int unsigned CFG_RAMP_BIT    = 4;
    localparam int unsigned STS_RED_BIT     = 0;
    localparam int unsigned STS_GRN_BIT     = 1;
    localparam int unsigned STS_HEAT_BIT    = 2;

    // Writable masks and reset values.
    localparam logic [7:0] CTRL_MASK  = 8'h07;
    localparam logic [7:0] CFG_MASK   = 8'h1f;
    localparam logic [7:0] DUTY_MASK  = 8'h3f;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET  = 8'h01;
    localparam logic [7:0] DUTY_RESET = 8'h00;

    typedef enum logic [1:0] {
        DLPWM_REP_256HZ,
        DLPWM_REP_8HZ,
        DLPWM_REP_1HZ,
        DLPWM_REP_HALF_HZ
    } dlpwm_rep_e;

    // Timing-clock ticks per PWM slot; 32 slots make one period.
    localparam logic [11:0] PRE_256HZ  = 12'h004;
    localparam logic [11:0] PRE_8HZ    = 12'h080;
    localparam logic [11:0] PRE_1HZ    = 12'h400;
    localparam logic [11:0] PRE_HALF   = 12'h800;
    localparam logic [4:0]  SLOT_LAST  = 5'h1f;
    localparam logic [5:0]  DUTY_FULL  = 6'h20;
    localparam logic [5:0]  DUTY_ZERO  = 6'h00;
    localparam int unsigned RAMP_HZ    = 64;
    localparam logic [9:0]  RAMP_TICKS = 10'(TIMING_HZ / RAMP_HZ);

    function automatic logic [5:0] dlpwm_duty_of(input logic [5:0] code);
        dlpwm_duty_of = code[5] ? DUTY_FULL : {1'b0, code[4:0]};
    endfunction

    function automatic logic [11:0] dlpwm_prescale(input dlpwm_rep_e rep);
        case (rep)
            DLPWM_REP_256HZ: dlpwm_prescale = PRE_256HZ;
            DLPWM_REP_8HZ:   dlpwm_prescale = PRE_8HZ;
            DLPWM_REP_1HZ:   dlpwm_prescale = PRE_1HZ;
            default:         dlpwm_prescale = PRE_HALF;
        endcase
    endfunction

endpackage

// >>> rtl/dlpwm_top.sv
// Top of the dual LED PWM, ramp and blink controller with its register port.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dlpwm_top
    import dlpwm_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_DIV_DEFAULT
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_strobe,
    input  wire logic              rd_strobe,
    output var  logic [DATA_W-1:0] rdata,
    input  wire logic              heat_gate,
    output var  logic              red_led_sink,
    output var  logic              green_led_sink,
    output var  logic [1:0]        red_led_current_level,
    output var  logic [1:0]        green_led_current_level
);
    logic [7:0]            ctrl_reg,     ctrl_next;
    logic [7:0]            red_cfg_reg,  red_cfg_next;
    logic [7:0]            red_duty_reg, red_duty_next;
    logic [7:0]            grn_cfg_reg,  grn_cfg_next;
    logic [7:0]            grn_duty_reg, grn_duty_next;
    logic [DATA_W-1:0]     rdata_reg,    rdata_next;
    logic [TICK_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic                  tick_reg,     tick_next;
    logic                  heat_meta_reg;
    logic                  heat_sync_reg;
    logic                  heat_block;

    dlpwm_chan_if red_if ();
    dlpwm_chan_if grn_if ();

    // The heat pin is asynchronous; the first flop feeds only the second.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            heat_meta_reg <= 1'b0;
            heat_sync_reg <= 1'b0;
        end else begin
            heat_meta_reg <= heat_gate;
            heat_sync_reg <= heat_meta_reg;
        end
    end

    always_comb begin
        heat_block = heat_sync_reg;

        tick_next     = 1'b0;
        tick_cnt_next = tick_cnt_reg + 16'h0001;
        if (tick_cnt_reg == TICK_CNT_W'(TICK_DIV - 1)) begin
            tick_cnt_next = 16'h0000;
            tick_next     = 1'b1;
        end

        ctrl_next     = ctrl_reg;
        red_cfg_next  = red_cfg_reg;
        red_duty_next = red_duty_reg;
        grn_cfg_next  = grn_cfg_reg;
        grn_duty_next = grn_duty_reg;
        if (wr_strobe) begin
            case (address)
                ADDR_CTRL:     ctrl_next     = wdata & CTRL_MASK;
                ADDR_RED_CFG:  red_cfg_next  = wdata & CFG_MASK;
                ADDR_RED_DUTY: red_duty_next = wdata & DUTY_MASK;
                ADDR_GRN_CFG:  grn_cfg_next  = wdata & CFG_MASK;
                ADDR_GRN_DUTY: grn_duty_next = wdata & DUTY_MASK;
                default:       ctrl_next     = ctrl_reg;
            endcase
        end

        // Read data stand only in the cycle after the strobe; unmapped reads give zero.
        rdata_next = 8'h00;
        if (rd_strobe) begin
            case (address)
                ADDR_CTRL:     rdata_next = ctrl_reg;
                ADDR_RED_CFG:  rdata_next = red_cfg_reg;
                ADDR_RED_DUTY: rdata_next = red_duty_reg;
                ADDR_GRN_CFG:  rdata_next = grn_cfg_reg;
                ADDR_GRN_DUTY: rdata_next = grn_duty_reg;
                ADDR_STATUS: begin
                    rdata_next[STS_RED_BIT]  = red_if.sink;
                    rdata_next[STS_GRN_BIT]  = grn_if.sink;
                    rdata_next[STS_HEAT_BIT] = heat_sync_reg;
                end
                ADDR_RED_EFF:  rdata_next = {2'b00, red_if.eff_duty};
                ADDR_GRN_EFF:  rdata_next = {2'b00, grn_if.eff_duty};
                default:       rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_reg     <= CTRL_RESET;
            red_cfg_reg  <= CFG_RESET;
            red_duty_reg <= DUTY_RESET;
            grn_cfg_reg  <= CFG_RESET;
            grn_duty_reg <= DUTY_RESET;
            rdata_reg    <= 8'h00;
            tick_cnt_reg <= 16'h0000;
            tick_reg     <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            red_cfg_reg  <= red_cfg_next;
            red_duty_reg <= red_duty_next;
            grn_cfg_reg  <= grn_cfg_next;
            grn_duty_reg <= grn_duty_next;
            rdata_reg    <= rdata_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    assign red_if.gate = ctrl_reg[CTRL_RED_EN_BIT] && ctrl_reg[CTRL_OVR_BIT] && !heat_block;
    assign grn_if.gate = ctrl_reg[CTRL_GRN_EN_BIT] && ctrl_reg[CTRL_OVR_BIT] && !heat_block;
    assign red_if.tick = tick_reg;
    assign grn_if.tick = tick_reg;
    assign red_if.rep       = dlpwm_rep_e'(red_cfg_reg[CFG_REP_LSB +: 2]);
    assign grn_if.rep       = dlpwm_rep_e'(grn_cfg_reg[CFG_REP_LSB +: 2]);
    assign red_if.ramp_en   = red_cfg_reg[CFG_RAMP_BIT];
    assign grn_if.ramp_en   = grn_cfg_reg[CFG_RAMP_BIT];
    assign red_if.duty_code = red_duty_reg[5:0];
    assign grn_if.duty_code = grn_duty_reg[5:0];

    dlpwm_channel u_red (
        .mclk  (mclk),
        .reset (reset),
        .ch    (red_if)
    );

    dlpwm_channel u_grn (
        .mclk  (mclk),
        .reset (reset),
        .ch    (grn_if)
    );

    assign rdata          = rdata_reg;
    assign red_led_sink   = red_if.sink;
    assign green_led_sink = grn_if.sink;
    assign red_led_current_level   = red_cfg_reg[CFG_LEVEL_LSB +: 2];
    assign green_led_current_level = grn_cfg_reg[CFG_LEVEL_LSB +: 2];
endmodule
`default_nettype wire

// >>> verif/dlpwm_checker.sv
// Port-level assertions for the dual LED PWM block.
`timescale 1ns/10ps
`default_nettype none
module dlpwm_checker
    import dlpwm_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_DIV_DEFAULT
) (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic [3:0] address,
    input wire logic [7:0] wdata,
    input wire logic       wr_strobe,
    input wire logic       rd_strobe,
    input wire logic [7:0] rdata,
    input wire logic       heat_gate,
    input wire logic       red_led_sink,
    input wire logic       green_led_sink,
    input wire logic [1:0] red_led_current_level,
    input wire logic [1:0] green_led_current_level
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic       cw;
    logic [7:0] ctrl_m;
    logic [7:0] ctrl_d;
    assign cw = wr_strobe && address == ADDR_CTRL;
    // Copy of the control register rebuilt from bus traffic; the delayed copy covers the
    // cycle that the sink flop lags behind the gate.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_m <= CTRL_RESET;
            ctrl_d <= CTRL_RESET;
        end else begin
            ctrl_m <= cw ? (wdata & CTRL_MASK) : ctrl_m;
            ctrl_d <= ctrl_m;
        end
    end
    // The heat input passes two sync flops, so four samples leave margin.
    heat_off_a:
    assert property (heat_gate [*4] |=> !red_led_sink && !green_led_sink)
        else $error("sink on while hot");
    ovr_off_a:
    assert property (!ctrl_m[CTRL_OVR_BIT] && !ctrl_d[CTRL_OVR_BIT]
        |-> !red_led_sink && !green_led_sink) else $error("sink on without override");
    red_dis_a:
    assert property (!ctrl_m[CTRL_RED_EN_BIT] && !ctrl_d[CTRL_RED_EN_BIT]
        |-> !red_led_sink) else $error("red on while disabled");
    grn_dis_a:
    assert property (!ctrl_m[CTRL_GRN_EN_BIT] && !ctrl_d[CTRL_GRN_EN_BIT]
        |-> !green_led_sink) else $error("green on while disabled");
    red_lvl_a:
    assert property (wr_strobe && address == ADDR_RED_CFG
        |=> red_led_current_level == $past(wdata[1:0])) else $error("red level");
    grn_lvl_a:
    assert property (wr_strobe && address == ADDR_GRN_CFG
        |=> green_led_current_level == $past(wdata[1:0])) else $error("green level");
    red_hold_a:
    assert property (!(wr_strobe && address == ADDR_RED_CFG)
        |=> $stable(red_led_current_level)) else $error("red level moved");
    grn_hold_a:
    assert property (!(wr_strobe && address == ADDR_GRN_CFG)
        |=> $stable(green_led_current_level)) else $error("green level moved");
    cover property (heat_gate [*4]);
    cover property (red_led_sink && green_led_sink);
    cover property (rd_strobe && address == ADDR_RED_EFF);
endmodule
bind dlpwm_top dlpwm_checker #(.TICK_DIV(TICK_DIV)) u_dlpwm_checker (
    .mclk(mclk), .reset(reset), .address(address), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .heat_gate(heat_gate), .red_led_sink(red_led_sink),
    .green_led_sink(green_led_sink), .red_led_current_level(red_led_current_level),
    .green_led_current_level(green_led_current_level));
`default_nettype wire

// >>> verif/dlpwm_led_model.sv
// Pair of indicator LEDs that sum their lit cycles over a window.
`timescale 1ns/10ps
`default_nettype none
module dlpwm_led_model (
    input  wire logic        mclk,
    input  wire logic        clear,
    input  wire logic        red_led_sink,
    input  wire logic        green_led_sink,
    output var  logic [15:0] red_on,
    output var  logic [15:0] green_on
);
    // Perceived brightness is the lit fraction, so only the sum matters.
    always_ff @(posedge mclk) begin
        red_on   <= clear ? 16'h0000 : red_on + 16'(red_led_sink);
        green_on <= clear ? 16'h0000 : green_on + 16'(green_led_sink);
    end
endmodule
`default_nettype wire

// >>> verif/dlpwm_top_tb.sv
// Self-checking bench for the dual LED PWM, ramp and blink block.
`timescale 1ns/10ps
`default_nettype none
module dlpwm_top_tb
    import dlpwm_pkg::*;
;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  address = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr_strobe = 1'b0;
    logic        rd_strobe = 1'b0;
    logic        heat_gate = 1'b0;
    logic        clear = 1'b1;
    logic [7:0]  rdata, v;
    logic        red_sink, grn_sink;
    logic [1:0]  red_lvl, grn_lvl;
    logic [15:0] red_on, green_on;
    int          err_total = 0;
    int          check_count = 0;
    int          gap;
    always #2.5 mclk = ~mclk;
    // A short tick divider keeps a 256 Hz period at 512 clocks.
    dlpwm_top #(.TICK_DIV(4)) u_dlpwm_top (.mclk(mclk), .reset(reset),
        .address(address), .wdata(wdata), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata), .heat_gate(heat_gate),
        .red_led_sink(red_sink), .green_led_sink(grn_sink),
        .red_led_current_level(red_lvl), .green_led_current_level(grn_lvl));
    dlpwm_led_model u_dlpwm_led_model (.mclk(mclk), .clear(clear),
        .red_led_sink(red_sink), .green_led_sink(grn_sink),
        .red_on(red_on), .green_on(green_on));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        address <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge mclk);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        address <= a;
        rd_strobe <= 1'b1;
        @(posedge mclk);
        rd_strobe <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        chk({8'h00, v}, {8'h00, e});
    endtask
    // Counting a whole number of periods makes the sum independent of phase.
    task automatic measure(input int n, input logic [15:0] er, input logic [15:0] eg);
        @(posedge mclk);
        clear <= 1'b1;
        @(posedge mclk);
        clear <= 1'b0;
        repeat (n) @(posedge mclk);
        #1;
        chk(red_on, er);
        chk(green_on, eg);
    endtask
    task automatic poll(input logic [7:0] old);
        gap = 0;
        v = old;
        while (v === old && gap < 3000) begin
            rd(ADDR_RED_EFF);
            gap += 2;
        end
        if (gap >= 3000) begin
            err_total++;
            close_out();
        end
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        chk({14'h0000, red_lvl}, 16'h0001);
        rchk(ADDR_CTRL, CTRL_RESET);
        rchk(ADDR_GRN_CFG, CFG_RESET);
        wr(4'hf, 8'hff);
        rchk(4'hf, 8'h00);
        rchk(ADDR_CTRL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_RED_CFG, 8'(i));
            #1 chk({14'h0000, red_lvl}, 16'(i));
            chk({14'h0000, grn_lvl}, 16'h0001);
        end
        wr(ADDR_RED_CFG, 8'he1);
        rchk(ADDR_RED_CFG, 8'he1 & CFG_MASK);
        wr(ADDR_CTRL, 8'h07);
        wr(ADDR_RED_DUTY, 8'h10);
        rchk(ADDR_RED_EFF, 8'h10);
        wr(ADDR_GRN_DUTY, 8'h25);
        rchk(ADDR_GRN_EFF, 8'h20);
        repeat (1100) @(posedge mclk);
        measure(512, 16'h0100, 16'h0200);
        @(posedge mclk);
        heat_gate <= 1'b1;
        repeat (8) @(posedge mclk);
        measure(512, 16'h0000, 16'h0000);
        rchk(ADDR_STATUS, 8'h04);
        @(posedge mclk);
        heat_gate <= 1'b0;
        wr(ADDR_CTRL, 8'h06);
        measure(512, 16'h0000, 16'h0000);
        rchk(ADDR_STATUS, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        measure(512, 16'h0000, 16'h0000);
        wr(ADDR_CTRL, 8'h07);
        wr(ADDR_GRN_DUTY, 8'h00);
        repeat (1100) @(posedge mclk);
        measure(512, 16'h0100, 16'h0000);
        wr(ADDR_GRN_CFG, 8'h15);
        wr(ADDR_GRN_DUTY, 8'h08);
        rchk(ADDR_GRN_EFF, 8'h08);
        repeat (16500) @(posedge mclk);
        measure(16384, 16'h2000, 16'h1000);
        wr(ADDR_RED_CFG, 8'h11);
        wr(ADDR_RED_DUTY, 8'h14);
        for (int k = 17; k <= 20; k++) begin
            poll(8'(k - 1));
            chk({8'h00, v}, 16'(k));
            if (k == 18) chk(16'(gap >= 2044 && gap <= 2052), 16'h0001);
        end
        repeat (2100) @(posedge mclk);
        rchk(ADDR_RED_EFF, 8'h14);
        wr(ADDR_RED_DUTY, 8'h12);
        poll(8'h14);
        chk({8'h00, v}, 16'h0013);
        wr(ADDR_RED_CFG, 8'h19);
        wr(ADDR_RED_DUTY, 8'h05);
        rchk(ADDR_RED_EFF, 8'h05);
        wr(ADDR_GRN_CFG, 8'h1e);
        #1 chk({14'h0000, grn_lvl}, 16'h0002);
        chk({14'h0000, red_lvl}, 16'h0001);
        wr(ADDR_GRN_DUTY, 8'h03);
        rchk(ADDR_GRN_EFF, 8'h03);
        // Going from the slowest rate back to 256 Hz makes the prescaler wrap.
        wr(ADDR_CTRL, 8'h05);
        wr(ADDR_GRN_CFG, 8'h02);
        repeat (1100) @(posedge mclk);
        measure(512, 16'h0000, 16'h0030);
        close_out();
    end
endmodule
`default_nettype wire
